/* psw_serial.sv */
// Operation
// RL1: Data holds steady at each rising link clock edge, where it is taken.
// RL2: The link clock pin is an input after reset, driven only when selected.
// RL3: A driven link clock is the host-bus clock divided by thirty-six.
// RL4: An outside link clock source keeps it at or below two megahertz.
// RL5: Settings go to the switch one bit at a time on the data output.
// RL6: The latch output tells the switch that the shifted data is valid.
// RL7: Host reset outside suspend floats outputs, clears state, stops work.
// RL8: After host reset is released the block starts from its default state.
// RL9: In suspend, host reset floats the outputs but keeps the stored state.
// RL10: All host-bus inputs are sampled on the rising host-bus clock edge.
// RL11: A clkrun stop request is refused by holding the clock while busy.
// RL12: The host-bus clock supplied is no faster than thirty-three megahertz.
// RL13: Data moves only on a link clock fall; latch follows the last bit.
`include "psw_serial_regs.svh"
module psw_serial #(
  parameter int SET_W = `PSW_SET_WIDTH
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // Host-bus system pins
  input wire logic host_bus_reset_n,
  input wire logic suspend_mode,
  input wire logic switch_clock_output_select,
  input wire logic clkrun_n_i,
  output logic clkrun_n_o,
  output logic clkrun_n_oe,
  // Setting to send
  input wire logic [SET_W-1:0] set_data,
  input wire logic set_valid,
  output logic set_ready,
  // Power switch link
  input wire logic link_clk_i,
  output logic link_clk_o,
  output logic link_clk_oe,
  output logic link_data_o,
  output logic link_data_oe,
  output logic link_latch_o,
  output logic link_latch_oe
);
  import psw_serial_pkg::*;

  localparam int CW = $clog2(SET_W + 1);

  logic rst_meta_q, rst_q;
  logic [`PSW_SYNC_N-1:0] pins_s;
  logic hbr_n_s, susp_s, sel_s, ext_clk_s, clkrun_s;
  logic ext_clk_d1_q;
  logic [5:0] div_q, div_d;
  logic drv_clk_q;
  psw_state_t state_q, state_d;
  logic [SET_W-1:0] shift_q, shift_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic data_q, data_d, latch_q, latch_d;

  // Reset release through two flops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q <= rst_meta_q;
    end
  end

  // Pins pass two flops before use
  psw_sync #(.N(`PSW_SYNC_N)) u_sync (
    .clock(clock),
    .rst_b(rst_q),
    .clk_en(clk_en),
    .d({clkrun_n_i, link_clk_i, switch_clock_output_select, suspend_mode,
        host_bus_reset_n}),
    .q(pins_s)
  ); // RL10

  assign hbr_n_s = pins_s[0];
  assign susp_s = pins_s[1];
  assign sel_s = pins_s[2];
  assign ext_clk_s = pins_s[3];
  assign clkrun_s = pins_s[4];

  // Host reset outside suspend clears state; any host reset floats pins
  wire hb_clear = !hbr_n_s && !susp_s; // RL7
  wire hb_float = !hbr_n_s; // RL7 RL9

  // Divider for the driven link clock
  wire div_last = div_q == 6'(`PSW_DIV_RATIO - 1);
  assign div_d = div_last ? 6'h00 : div_q + 6'h01; // RL3
  wire drv_rise = sel_s && div_q == `PSW_DIV_RISE;
  wire drv_fall = sel_s && div_q == `PSW_DIV_FALL;

  // Edges of the outside link clock
  wire ext_rise = !sel_s && ext_clk_s && !ext_clk_d1_q;
  wire ext_fall = !sel_s && !ext_clk_s && ext_clk_d1_q;
  wire link_fall = drv_fall || ext_fall; // RL13
  wire link_rise = drv_rise || ext_rise; // RL1

  wire idle = state_q == PSW_IDLE;
  wire take = idle && set_valid && set_ready;

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    cnt_d = cnt_q;
    data_d = data_q;
    latch_d = latch_q;
    unique case (state_q)
      PSW_IDLE: begin
        if (take) begin
          shift_d = set_data;
          cnt_d = '0;
          state_d = PSW_SHIFT;
        end
      end
      PSW_SHIFT: begin
        if (link_fall) begin
          if (cnt_q == CW'(SET_W)) begin
            latch_d = 1'b1; // RL6 RL13
            state_d = PSW_LATCH;
          end else begin
            data_d = shift_q[SET_W-1]; // RL5 RL13
            shift_d = {shift_q[SET_W-2:0], 1'b0};
            cnt_d = cnt_q + CW'(1);
          end
        end
      end
      PSW_LATCH: begin
        if (link_fall) begin
          latch_d = 1'b0;
          state_d = PSW_IDLE;
        end
      end
      default: state_d = PSW_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q) begin
      state_q <= PSW_IDLE;
      shift_q <= '0;
      cnt_q <= '0;
      data_q <= 1'b0;
      latch_q <= 1'b0;
      div_q <= 6'h00;
      drv_clk_q <= 1'b0;
      ext_clk_d1_q <= 1'b0;
    end else if (clk_en) begin
      if (hb_clear) begin // RL7 RL8
        state_q <= PSW_IDLE;
        shift_q <= '0;
        cnt_q <= '0;
        data_q <= 1'b0;
        latch_q <= 1'b0;
        div_q <= 6'h00;
        drv_clk_q <= 1'b0;
        ext_clk_d1_q <= 1'b0;
      end else begin // RL9
        state_q <= state_d;
        shift_q <= shift_d;
        cnt_q <= cnt_d;
        data_q <= data_d;
        latch_q <= latch_d;
        div_q <= sel_s ? div_d : 6'h00;
        if (drv_rise) drv_clk_q <= 1'b1; // RL3
        else if (drv_fall || !sel_s) drv_clk_q <= 1'b0;
        ext_clk_d1_q <= ext_clk_s;
      end
    end
  end

  // Registered pin drivers
  always_ff @(posedge clock or negedge rst_q) begin
    if (!rst_q) begin
      link_clk_o <= 1'b0;
      link_clk_oe <= 1'b0;
      link_data_o <= 1'b0;
      link_data_oe <= 1'b0;
      link_latch_o <= 1'b0;
      link_latch_oe <= 1'b0;
      clkrun_n_o <= 1'b0;
      clkrun_n_oe <= 1'b0;
      set_ready <= 1'b0;
    end else if (clk_en) begin
      link_clk_o <= drv_clk_q;
      link_clk_oe <= sel_s && !hb_float; // RL2
      link_data_o <= data_q;
      link_data_oe <= !hb_float; // RL7 RL9
      link_latch_o <= latch_q;
      link_latch_oe <= !hb_float;
      clkrun_n_o <= 1'b0;
      clkrun_n_oe <= clkrun_s && !idle && !hb_float; // RL11
      set_ready <= idle && !take && !hb_float;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_q);

  div_range_a: assert property (div_q < 6'(`PSW_DIV_RATIO)) // RL3
    else $error("divider beyond ratio");
  div_period_a: assert property (clk_en && !hb_clear && sel_s && div_last
      |=> div_q == 6'h00) // RL3
    else $error("divider did not restart");
  clk_input_a: assert property (clk_en && !sel_s |=> !link_clk_oe) // RL2
    else $error("link clock driven while not selected");
  float_out_a: assert property (clk_en && hb_float |=> !link_data_oe
      && !link_latch_oe && !link_clk_oe && !clkrun_n_oe) // RL7 RL9
    else $error("pins driven during host reset");
  clear_state_a: assert property (clk_en && hb_clear |=> idle && !latch_q
      && cnt_q == '0) // RL7
    else $error("state kept in host reset");
  keep_state_a: assert property (clk_en && !hbr_n_s && susp_s
      |=> shift_q == $past(shift_d)) // RL9
    else $error("suspend lost state");
  data_fall_a: assert property (!$stable(data_q)
      |-> $past(clk_en && (link_fall || hb_clear))) // RL13
    else $error("data moved off falling edge");
  data_rise_a: assert property (clk_en && link_rise && !hb_clear
      |=> $stable(data_q)) // RL1
    else $error("data moved at rising edge");
  latch_last_a: assert property ($rose(latch_q)
      |-> $past(cnt_q) == CW'(SET_W)) // RL6 RL13
    else $error("latch before final bit");
  clkrun_hold_a: assert property (clk_en && clkrun_s && !idle && !hb_float
      |=> clkrun_n_oe && !clkrun_n_o) // RL11
    else $error("clock stop not refused while busy");
endmodule // psw_serial

/* psw_serial_regs.svh */
`ifndef PSW_SERIAL_REGS_SVH
`define PSW_SERIAL_REGS_SVH
// Host-bus clock divide ratio for a driven link clock
`define PSW_DIV_RATIO 36
// Divider count at which the driven link clock rises and falls
`define PSW_DIV_RISE 6'h11
`define PSW_DIV_FALL 6'h23
// Default width of one power-control setting
`define PSW_SET_WIDTH 8
// Pin synchroniser inputs: reset, suspend, clock select, link clock, clkrun
`define PSW_SYNC_N 5
`endif

/* psw_serial_pkg.sv */
package psw_serial_pkg;
  typedef enum logic [1:0] {
    PSW_IDLE = 2'b00,
    PSW_SHIFT = 2'b01,
    PSW_LATCH = 2'b10
  } psw_state_t;
endpackage

/* psw_sync.sv */
module psw_sync #(
  parameter int N = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  // Asynchronous levels in, synchronised levels out
  input wire logic [N-1:0] d,
  output logic [N-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else if (clk_en) begin
          meta_q <= d[i];
          sync_q <= meta_q;
        end
      end
      assign q[i] = sync_q;
    end
  endgenerate
endmodule // psw_sync

/* psw_switch_model.sv */
module psw_switch_model (
  // Link pins
  input wire logic link_clk,
  input wire logic link_data,
  input wire logic link_latch,
  // Setting taken by the switch
  output logic [7:0] taken
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] shift_q = 8'h00;
  initial taken = 8'h00;
  always @(posedge link_clk) shift_q <= {shift_q[6:0], link_data};
  always @(posedge link_latch) taken <= shift_q;
endmodule // psw_switch_model

/* test_card_power_switch_serial.sv */
module test_card_power_switch_serial;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic hrst_n = 1'b1;
  logic susp = 1'b0;
  logic sel = 1'b0;
  logic crun = 1'b0;
  logic [7:0] sdata = 8'h00;
  logic svalid = 1'b0;
  logic ext_clk = 1'b1;
  logic ext_run = 1'b0;
  // Host-bus rate of 25 MHz: one enabled edge in four
  logic [1:0] cph = 2'h0;
  wire cen = cph == 2'h0;
  logic set_ready, clkrun_n_o, clkrun_n_oe, link_clk_o, link_clk_oe;
  logic link_data_o, link_data_oe, link_latch_o, link_latch_oe;
  logic [7:0] taken;
  wire [7:0] oes = {set_ready, link_clk_oe, link_data_oe, link_latch_oe,
    4'h0};
  time t0;
  int err_count = 0;
  int compares = 0;
  int n;
  // Rows: select, clock stop request, setting
  logic [9:0] rows [4] = '{10'h3a5, 10'h201, 10'h180, 10'h0ff};
  wire lclk = link_clk_oe ? link_clk_o : ext_clk;
  wire ldat = link_data_oe ? link_data_o : ~link_data_o;
  wire llat = link_latch_oe ? link_latch_o : ~link_latch_o;
  psw_serial #(.SET_W(8)) dut_u (.clock(clock), .rst_b(rst_b),
    .clk_en(cen), .host_bus_reset_n(hrst_n), .suspend_mode(susp),
    .switch_clock_output_select(sel), .clkrun_n_i(crun),
    .clkrun_n_o(clkrun_n_o), .clkrun_n_oe(clkrun_n_oe), .set_data(sdata),
    .set_valid(svalid), .set_ready(set_ready), .link_clk_i(lclk),
    .link_clk_o(link_clk_o), .link_clk_oe(link_clk_oe),
    .link_data_o(link_data_o), .link_data_oe(link_data_oe),
    .link_latch_o(link_latch_o), .link_latch_oe(link_latch_oe));
  psw_switch_model model_u (.link_clk(lclk), .link_data(ldat),
    .link_latch(llat), .taken(taken));
  always #5 clock = ~clock;
  always @(negedge clock) cph <= cph + 2'h1;
  // Outside link clock of 2 MHz, idle high between frames
  always begin
    #250;
    ext_clk = ext_run ? ~ext_clk : 1'b1;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task send(input logic [9:0] r);
    sel = r[9];
    crun = r[8];
    sdata = r[7:0];
    repeat (16) @(negedge clock);
    chk({7'h00, link_clk_oe}, {7'h00, r[9]});
    ext_run = ~r[9];
    svalid = 1'b1;
    n = 0;
    while (set_ready !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    chk({7'h00, set_ready}, 8'h01);
    n = 0;
    while (set_ready === 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    chk({7'h00, set_ready}, 8'h00);
    svalid = 1'b0;
    repeat (40) @(negedge clock);
    chk({6'h00, clkrun_n_oe, clkrun_n_o}, {6'h00, r[8], 1'b0});
    n = 0;
    while (set_ready !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    chk({7'h00, set_ready}, 8'h01);
    ext_run = 1'b0;
    chk(taken, r[7:0]);
  endtask
  initial begin
    #200000;
    err_count++;
    end_sim;
  end
  initial begin
    repeat (6) @(negedge clock);
    rst_b = 1'b1;
    repeat (16) @(negedge clock);
    chk({7'h00, link_clk_oe}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      send(rows[i]);
    end
    sel = 1'b1;
    @(posedge link_clk_o);
    t0 = $time;
    @(posedge link_clk_o);
    // Enabled edges lie 40 ns apart
    chk(8'(($time - t0) / 40), 8'h24);
    @(negedge clock);
    hrst_n = 1'b0;
    repeat (16) @(negedge clock);
    chk(oes, 8'h00);
    hrst_n = 1'b1;
    repeat (16) @(negedge clock);
    chk(oes, 8'hf0);
    susp = 1'b1;
    hrst_n = 1'b0;
    repeat (16) @(negedge clock);
    chk(oes, 8'h00);
    hrst_n = 1'b1;
    susp = 1'b0;
    repeat (16) @(negedge clock);
    send(10'h25a);
    end_sim;
  end
endmodule // test_card_power_switch_serial
